// ===== bench/msd_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Self-checking bench for the memory space decoder
// ==========================================================
module msd_decoder_tb;
  import msd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  msd_rf_req_type rfReq = '0;
  msd_pm_req_type pmReq = '0;
  logic [7:0] pageSelect = 8'h00;
  logic dmReq = 1'b0;
  msd_rsp_type rfRsp, pmRsp;
  logic ctrlReq, ctrlWr, flashReq, flashWr, dmAck;
  logic [7:0] ctrlAddr, ctrlWdata, ctrlRdata, flashWdata, flashRdata, vectorRegion;
  logic [15:0] flashAddr;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  msd_decoder DUT (.clk_sys, .sys_rst, .rfReq, .rfRsp, .ctrlReq, .ctrlWr, .ctrlAddr,
    .ctrlWdata, .ctrlRdata, .pmReq, .pmRsp, .flashReq, .flashWr, .flashAddr, .flashWdata,
    .flashRdata, .pageSelect, .dmReq, .dmAck, .vectorRegion);
  msd_mem_model partner (.ctrlReq, .ctrlAddr, .flashReq, .flashAddr, .ctrlRdata,
    .flashRdata);

  always #2 clk_sys = ~clk_sys;

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // The run normally needs about 90 cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      results();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  // ==========================================================
  // Bus cycles
  // ==========================================================
  task automatic rf(input logic wr, input logic [11:0] a, input logic [7:0] d,
                    input logic ctl, input logic [7:0] exp);
    @(posedge clk_sys);
    rfReq <= '{1'b1, wr, a, d};
    @(posedge clk_sys);
    rfReq <= '0;
    #1;
    chk1("ctrlReq", ctl, ctrlReq);
    if (ctl) chk8("ctrlAddr", a[7:0], ctrlAddr);
    if (ctl) chk1("ctrlWr", wr, ctrlWr);
    if (ctl && wr) chk8("ctrlWdata", d, ctrlWdata);
    @(posedge clk_sys);
    #1;
    chk1("rfValid", 1'b1, rfRsp.valid);
    if (!wr) chk8("rfData", exp, rfRsp.rdata);
  endtask : rf

  task automatic pm(input logic wr, input logic [15:0] a, input logic fl,
                    input logic [7:0] exp, input logic [7:0] vr);
    @(posedge clk_sys);
    pmReq <= '{1'b1, wr, a, 8'h33};
    @(posedge clk_sys);
    pmReq <= '0;
    #1;
    chk1("flashReq", fl, flashReq);
    if (fl) chk8("flashAddrLo", a[7:0], flashAddr[7:0]);
    if (fl) chk8("flashAddrHi", a[15:8], flashAddr[15:8]);
    if (fl) chk1("flashWr", wr, flashWr);
    if (fl && wr) chk8("flashWdata", 8'h33, flashWdata);
    @(posedge clk_sys);
    #1;
    chk1("pmValid", 1'b1, pmRsp.valid);
    if (!wr) chk8("pmData", exp, pmRsp.rdata);
    if (!wr) chk8("vectorRegion", vr, vectorRegion);
  endtask : pm

  function automatic logic [7:0] fexp(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : fexp

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_ram();
    rf(1'b1, 12'h000, 8'h5a, 1'b0, 8'h00);
    rf(1'b1, 12'h0ff, 8'ha5, 1'b0, 8'h00);
    rf(1'b0, 12'h0ff, 8'h00, 1'b0, 8'ha5);
    rf(1'b0, 12'h000, 8'h00, 1'b0, 8'h5a);
  endtask : t_ram

  task automatic t_hole();
    rf(1'b1, 12'h100, 8'h77, 1'b0, 8'h00);
    rf(1'b0, 12'h100, 8'h00, 1'b0, 8'hff);
    rf(1'b0, 12'heff, 8'h00, 1'b0, 8'hff);
    rf(1'b0, 12'h000, 8'h00, 1'b0, 8'h5a);
  endtask : t_hole

  // Control window accesses, assigned or not, all reach the control port.
  task automatic t_ctrl();
    rf(1'b1, 12'hf00, 8'h12, 1'b1, 8'h00);
    rf(1'b0, 12'hfff, 8'h00, 1'b1, 8'h00);
    rf(1'b0, 12'hf00, 8'h00, 1'b1, 8'hff);
  endtask : t_ctrl

  task automatic t_flash();
    logic [15:0] adr [5] = '{16'h0000, 16'h0002, 16'h0004, 16'h003e, 16'h1fff};
    logic [7:0] reg_v [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h08};
    for (int i = 0; i < 5; i++) pm(1'b0, adr[i], 1'b1, fexp(adr[i]), reg_v[i]);
    pm(1'b0, 16'h2000, 1'b0, 8'hff, 8'h00);
    pm(1'b1, 16'h2000, 1'b0, 8'h00, 8'h00);
    pm(1'b1, 16'h0100, 1'b1, 8'h00, 8'h00);
    pm(1'b0, 16'hffff, 1'b0, 8'hff, 8'h00);
  endtask : t_flash

  task automatic t_info();
    @(posedge clk_sys);
    pageSelect <= 8'h80;
    pm(1'b0, 16'hfe40, 1'b0, 8'h50, 8'h00);
    pm(1'b0, 16'hfe47, 1'b0, 8'h30, 8'h00);
    pm(1'b0, 16'hfe53, 1'b0, 8'hff, 8'h00);
    pm(1'b1, 16'hfe40, 1'b0, 8'h00, 8'h00);
    pm(1'b0, 16'hfe40, 1'b0, 8'h50, 8'h00);
    @(posedge clk_sys);
    pageSelect <= 8'h7f;
    pm(1'b0, 16'hfe40, 1'b0, 8'hff, 8'h00);
    pm(1'b0, 16'hfe7f, 1'b0, 8'hff, 8'h00);
  endtask : t_info

  task automatic t_data();
    @(posedge clk_sys);
    dmReq <= 1'b1;
    @(posedge clk_sys);
    dmReq <= 1'b0;
    #1;
    chk1("dmAck", 1'b1, dmAck);
    chk1("flashReq", 1'b0, flashReq);
    @(posedge clk_sys);
    #1;
    chk1("dmAck", 1'b0, dmAck);
  endtask : t_data

  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    chk1("rfValid", 1'b0, rfRsp.valid);
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_ram();
    t_hole();
    t_ctrl();
    t_flash();
    t_info();
    t_data();
    results();
  end
endmodule : msd_decoder_tb

`default_nettype wire

// ===== bench/msd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Control register and flash stand-ins behind the decoder
// ==========================================================
// Outside a request each bus carries the inverse of its answer.
// A sample taken on the wrong cycle therefore reads back wrong.
module msd_mem_model (
  input wire logic ctrlReq,
  input wire logic [7:0] ctrlAddr,
  input wire logic flashReq,
  input wire logic [15:0] flashAddr,
  output logic [7:0] ctrlRdata,
  output logic [7:0] flashRdata
);
  logic [7:0] flashVal;
  assign flashVal = flashAddr[7:0] ^ flashAddr[15:8] ^ 8'h3c;
  assign flashRdata = flashReq ? flashVal : ~flashVal;
  assign ctrlRdata = ctrlReq ? ~ctrlAddr : ctrlAddr;
endmodule : msd_mem_model

`default_nettype wire

// ===== rtl/msd_decoder.sv
// Functional notes
// - Register file space is 4096 bytes: general RAM plus control registers.
// - Top 256 locations F00-FFF go to the control register port, not RAM.
// - Unassigned control reads complete normally with undefined data.
// - RAM starts at address zero, at most 256 bytes.
// - Between RAM top and control window: undefined read, writes ignored.
// - Program space is 64KB; reads beyond flash return FF.
// - Writes to unimplemented program addresses change nothing.
// - Flash is 1KB to 12KB from address zero, per variant.
// - Option bits, reset vector, interrupt vectors, then code to flash top.
// - No data memory space; data accesses hit no storage.
// - Info area enabled by bit 7 of the flash page select value.
// - While enabled, reads FE00-FE7F return info area contents.
// - Info area is read-only through the overlay.
// - FE40-FE53 hold 20-char ASCII part id, padded with FF.
`timescale 1ns/10ps
`default_nettype none
`include "msd_map.svh"

module msd_decoder
  import msd_pkg::*;
#(
  parameter int RAM_BYTES = 256,
  parameter int FLASH_BYTES = 8192,
  // Arbitrary identifier text; each variant overrides it with its own.
  parameter logic [159:0] PART_ID = {"PART-ID0", {12{8'hff}}}
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire msd_rf_req_type rfReq,
  output msd_rsp_type rfRsp,
  output logic ctrlReq,
  output logic ctrlWr,
  output logic [7:0] ctrlAddr,
  output logic [7:0] ctrlWdata,
  input wire logic [7:0] ctrlRdata,
  input wire msd_pm_req_type pmReq,
  output msd_rsp_type pmRsp,
  output logic flashReq,
  output logic flashWr,
  output logic [15:0] flashAddr,
  output logic [7:0] flashWdata,
  input wire logic [7:0] flashRdata,
  input wire logic [7:0] pageSelect,
  input wire logic dmReq,
  output logic dmAck,
  output logic [7:0] vectorRegion
);
  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic rfPend;
    msd_rf_region_type rfRegion;
    logic rfVld;
    logic [7:0] rfData;
    logic ctrlReq;
    logic ctrlWr;
    logic [7:0] ctrlAddr;
    logic [7:0] ctrlWdata;
    logic pmPend;
    msd_pm_region_type pmRegion;
    logic [6:0] infoAddr;
    logic pmVld;
    logic [7:0] pmData;
    logic flashReq;
    logic flashWr;
    logic [15:0] flashAddr;
    logic [7:0] flashWdata;
    logic dmAck;
    logic [7:0] vecReg;
  } msd_state_type;

  msd_state_type state_r;
  msd_state_type state_nxt;
  logic [7:0] ram_r [RAM_BYTES];
  logic [7:0] ramRd_r;
  logic [7:0] infoData;
  logic infoEn;
  logic ramHit;
  logic ramWe;
  logic [7:0] ramIdx;

  // The table keeps no state and has no write path at all.
  msd_info_rom #(.PART_ID(PART_ID)) u_info (
    .addr(state_r.infoAddr),
    .data(infoData)
  );

  // ==========================================================================
  // Register file RAM
  // ==========================================================================
  assign ramHit = ({20'h0, rfReq.addr} < RAM_BYTES);
  assign ramIdx = rfReq.addr[7:0];
  assign ramWe = rfReq.req && rfReq.wr && ramHit;

  // RAM content is not reset, as real register RAM powers up unknown.
  // The read is registered like a block RAM, so a read that meets a write to
  // the same byte in one cycle returns the old byte.
  always_ff @(posedge clk_sys) begin
    if (ramWe) begin
      ram_r[ramIdx] <= rfReq.wdata;
    end
    ramRd_r <= ram_r[ramIdx];
  end

  assign infoEn = pageSelect[`MSD_PSEL_INFO_BIT];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    state_nxt.rfVld = 1'b0;
    state_nxt.pmVld = 1'b0;
    state_nxt.ctrlReq = 1'b0;
    state_nxt.flashReq = 1'b0;
    state_nxt.rfPend = 1'b0;
    state_nxt.pmPend = 1'b0;
    // Data space is unbacked: acknowledge and move on, nothing stored.
    state_nxt.dmAck = dmReq;

    // Both spaces are pipelined alike, so back-to-back requests overlap.
    // Two-stage access: stage one decodes and launches, stage two answers.
    if (rfReq.req) begin
      state_nxt.rfPend = 1'b1;
      if (rfReq.addr[11:8] == `MSD_RF_CTRL_NIB) begin
        state_nxt.rfRegion = MSD_RF_CTRL;
        state_nxt.ctrlReq = 1'b1;
        state_nxt.ctrlWr = rfReq.wr;
        state_nxt.ctrlAddr = rfReq.addr[7:0];
        state_nxt.ctrlWdata = rfReq.wdata;
      end else if (ramHit) begin
        state_nxt.rfRegion = MSD_RF_RAM;
      end else begin
        state_nxt.rfRegion = MSD_RF_HOLE;
      end
    end
    if (state_r.rfPend) begin
      state_nxt.rfVld = 1'b1;
      case (state_r.rfRegion)
        MSD_RF_RAM: state_nxt.rfData = ramRd_r;
        // Reserved control slots answer whatever the peripheral bus floats.
        MSD_RF_CTRL: state_nxt.rfData = ctrlRdata;
        default: state_nxt.rfData = `MSD_PM_ERASED;
      endcase
    end

    if (pmReq.req) begin
      state_nxt.pmPend = 1'b1;
      state_nxt.infoAddr = pmReq.addr[6:0];
      // Classes: 01 option bits, 02 reset vector, 04 interrupt vectors, 08 code.
      state_nxt.vecReg = 8'h00;
      if (pmReq.addr <= `MSD_PM_OPT_HI) begin
        state_nxt.vecReg = 8'h01;
      end else if (pmReq.addr <= `MSD_PM_RSTV_HI) begin
        state_nxt.vecReg = 8'h02;
      end else if (pmReq.addr <= `MSD_PM_IVEC_HI) begin
        state_nxt.vecReg = 8'h04;
      end else if ({16'h0, pmReq.addr} < FLASH_BYTES) begin
        state_nxt.vecReg = 8'h08;
      end
      // The window test comes first, so an enabled overlay would hide flash
      // even in a variant large enough to reach that far.
      if (infoEn && pmReq.addr[15:7] == `MSD_INFO_BASE_HI) begin
        state_nxt.pmRegion = MSD_PM_INFO;
      end else if ({16'h0, pmReq.addr} < FLASH_BYTES) begin
        state_nxt.pmRegion = MSD_PM_FLASH;
        state_nxt.flashReq = 1'b1;
        state_nxt.flashWr = pmReq.wr;
        state_nxt.flashAddr = pmReq.addr;
        state_nxt.flashWdata = pmReq.wdata;
      end else begin
        state_nxt.pmRegion = MSD_PM_EMPTY;
      end
    end
    if (state_r.pmPend) begin
      state_nxt.pmVld = 1'b1;
      case (state_r.pmRegion)
        MSD_PM_FLASH: state_nxt.pmData = flashRdata;
        MSD_PM_INFO: state_nxt.pmData = infoData;
        default: state_nxt.pmData = `MSD_PM_ERASED;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign rfRsp = '{valid: state_r.rfVld, rdata: state_r.rfData};
  assign pmRsp = '{valid: state_r.pmVld, rdata: state_r.pmData};
  assign ctrlReq = state_r.ctrlReq;
  assign ctrlWr = state_r.ctrlWr;
  assign ctrlAddr = state_r.ctrlAddr;
  assign ctrlWdata = state_r.ctrlWdata;
  assign flashReq = state_r.flashReq;
  assign flashWr = state_r.flashWr;
  assign flashAddr = state_r.flashAddr;
  assign flashWdata = state_r.flashWdata;
  assign dmAck = state_r.dmAck;
  assign vectorRegion = state_r.vecReg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Each check names the request in its antecedent and the answer in the same cycle or one or two edges later.
  // Reserved control reads are not checked for data, as they may return anything.
  a_ctrl_window: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.addr[11:8] == `MSD_RF_CTRL_NIB |=> ctrlReq && ctrlAddr == $past(rfReq.addr[7:0]))
    else $error("control window access not forwarded");

  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.wr && rfReq.addr[11:8] == `MSD_RF_CTRL_NIB
      |=> ctrlWr && ctrlWdata == $past(rfReq.wdata))
    else $error("control write not forwarded");

  a_ram_no_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.addr[11:8] != `MSD_RF_CTRL_NIB |=> !ctrlReq)
    else $error("non-control address reached control port");

  a_ram_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.wr && {20'h0, rfReq.addr} < RAM_BYTES |-> ramWe)
    else $error("RAM write not enabled");

  a_rf_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req |=> ##1 rfRsp.valid)
    else $error("register access did not complete");

  a_rf_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !rfReq.req |=> ##1 !rfRsp.valid)
    else $error("register answer without request");

  a_hole_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.wr && rfReq.addr >= `MSD_RF_RAM_MAX |-> !ramWe)
    else $error("write above RAM reached storage");

  a_hole_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rfReq.req && rfReq.addr[11:8] != `MSD_RF_CTRL_NIB && {20'h0, rfReq.addr} >= RAM_BYTES
      |=> ##1 rfRsp.valid && rfRsp.rdata == `MSD_PM_ERASED)
    else $error("reserved register read not FF");

  a_pm_erased: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && !infoEn && {16'h0, pmReq.addr} >= FLASH_BYTES
      |=> !flashReq ##1 pmRsp.valid && pmRsp.rdata == `MSD_PM_ERASED)
    else $error("unimplemented program read not FF");

  a_pm_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req |=> ##1 pmRsp.valid)
    else $error("program access did not complete");

  a_pm_no_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && pmReq.wr && {16'h0, pmReq.addr} >= FLASH_BYTES |=> !flashReq)
    else $error("write beyond flash forwarded");

  a_flash_fwd: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && !(infoEn && pmReq.addr[15:7] == `MSD_INFO_BASE_HI)
      && {16'h0, pmReq.addr} < FLASH_BYTES
      |=> flashReq && flashAddr == $past(pmReq.addr) && flashWr == $past(pmReq.wr))
    else $error("flash access not forwarded");

  a_info_overlay: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && infoEn && pmReq.addr[15:7] == `MSD_INFO_BASE_HI
      |=> !flashReq ##1 pmRsp.valid && pmRsp.rdata == $past(infoData))
    else $error("info overlay read wrong");

  a_info_ro: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && pmReq.wr && infoEn && pmReq.addr[15:7] == `MSD_INFO_BASE_HI |=> !flashReq)
    else $error("info area write reached flash");

  // Holds while every variant's flash stays below the window.
  a_info_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && !infoEn && pmReq.addr[15:7] == `MSD_INFO_BASE_HI
      |=> ##1 pmRsp.rdata == `MSD_PM_ERASED)
    else $error("disabled info window not decoded as program memory");

  a_data_space: assert property (@(posedge clk_sys) disable iff (sys_rst)
    dmReq && !pmReq.req |=> dmAck && !flashReq)
    else $error("data space access not acknowledged");

  a_data_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !dmReq |=> !dmAck)
    else $error("data space acknowledged without request");

  a_vector_map: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && pmReq.addr == `MSD_PM_RSTV_LO |=> vectorRegion == 8'h02)
    else $error("reset vector not classified");

  a_vector_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && pmReq.addr >= `MSD_PM_CODE_LO && {16'h0, pmReq.addr} < FLASH_BYTES
      |=> vectorRegion == 8'h08)
    else $error("code area not classified");

  a_vector_none: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pmReq.req && {16'h0, pmReq.addr} >= FLASH_BYTES |=> vectorRegion == 8'h00)
    else $error("address beyond flash classified");
endmodule : msd_decoder
`default_nettype wire

// ===== rtl/msd_info_rom.sv
`timescale 1ns/10ps
`default_nettype none
`include "msd_map.svh"

// Read-only information area; a constant table, so writes cannot reach it.
module msd_info_rom
  import msd_pkg::*;
#(
  // Arbitrary identifier text, padded; the decoder passes each variant's own.
  parameter logic [159:0] PART_ID = {"PART-ID0", {12{8'hff}}}
) (
  input wire logic [6:0] addr,
  output logic [7:0] data
);
  logic [7:0] pnIdx;

  always_comb begin
    pnIdx = 8'({1'b0, addr} - {1'b0, `MSD_INFO_PN_LO});
    if (addr >= `MSD_INFO_PN_LO && addr <= `MSD_INFO_PN_HI) begin
      // First character sits in the top byte so text is left-justified.
      data = PART_ID[8'd159 - {pnIdx[4:0], 3'b000} -: 8];
    end else begin
      data = `MSD_INFO_PAD;
    end
  end
endmodule : msd_info_rom
`default_nettype wire

// ===== rtl/msd_map.svh
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
`define MSD_RF_AW 12
`define MSD_RF_CTRL_NIB 4'hf
`define MSD_RF_RAM_MAX 12'h100
`define MSD_PM_AW 16
`define MSD_PM_ERASED 8'hff
`define MSD_PM_OPT_LO 16'h0000
`define MSD_PM_OPT_HI 16'h0001
`define MSD_PM_RSTV_LO 16'h0002
`define MSD_PM_RSTV_HI 16'h0003
`define MSD_PM_IVEC_LO 16'h0004
`define MSD_PM_IVEC_HI 16'h003d
`define MSD_PM_CODE_LO 16'h003e
`define MSD_FLASH_MIN 32'd1024
`define MSD_FLASH_MAX 32'd12288
`define MSD_INFO_BASE_HI 9'h1fc
`define MSD_INFO_AW 7
`define MSD_INFO_PN_LO 7'h40
`define MSD_INFO_PN_HI 7'h53
`define MSD_PSEL_INFO_BIT 7
`define MSD_INFO_PAD 8'hff
`endif

// ===== rtl/msd_pkg.sv
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_RF_RAM = 2'b00,
    MSD_RF_HOLE = 2'b01,
    MSD_RF_CTRL = 2'b10
  } msd_rf_region_type;

  typedef enum logic [1:0] {
    MSD_PM_FLASH = 2'b00,
    MSD_PM_EMPTY = 2'b01,
    MSD_PM_INFO = 2'b10
  } msd_pm_region_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } msd_rf_req_type;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } msd_pm_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } msd_rsp_type;
endpackage : msd_pkg
